// ### hw/pwc_pulse_width_counter.sv
// What this block does
// RQ1: count ticks between opposite edges
// RQ2: debounce polarity picks high or low pulse
// RQ3: capture clears counter, next pulse armed
// RQ4: width latched at terminating edge
// RQ5: acquisition start clears counter and latches
// RQ6: four tick periods divided from clock
// RQ7: report whole tick intervals counted
// RQ8: width select: 16-bit or 32-bit counter
// RQ9: counter saturates, never wraps
// RQ10: gating: count only while mapped high
// RQ11: alternate source measures mapped channel
// RQ12: mapped channel selectable among debounced inputs
// RQ13: no averaging, one pulse per value
// RQ14: own read strobe captures latched value
// RQ15: scan reports latest width, repeats allowed
// RQ16: edges and counting synchronous, tick enabled
module pwc_pulse_width_counter
    import pwc_pkg::*;
#(
    parameter int NUM_INPUTS = 16,
    parameter int OWN_CHANNEL = 0
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_INPUTS-1:0] debouncedIn,
    input wire logic [NUM_INPUTS-1:0] edgePolarity,
    input wire logic scanStrobe,
    output logic [31:0] scanValue,
    output logic [31:0] latchedWidth,
    output logic captureStrobe
);

    // apb handshake state
    logic preadyReg;
    logic [31:0] prdataReg;
    logic pslverrReg;

    // control and status storage
    logic [11:0] ctrlReg;
    logic satStickyReg;
    logic validReg;

    // measurement storage
    pwc_state_type stateReg;
    pwc_state_type stateNext;
    logic [31:0] countReg;
    logic [31:0] countNext;
    logic [31:0] widthReg;
    logic [31:0] widthNext;
    logic [31:0] scanReg;
    logic captureReg;
    logic srcPrevReg;

    // apb decode
    wire apbAccess = psel && penable && !preadyReg;
    wire apbDone = psel && penable && preadyReg;
    wire hitCtrl = (paddr == PWC_CTRL_OFFSET);
    wire hitStatus = (paddr == PWC_STATUS_OFFSET);
    wire hitWidth = (paddr == PWC_WIDTH_OFFSET);
    wire hitScan = (paddr == PWC_SCAN_OFFSET);
    wire hitCount = (paddr == PWC_COUNT_OFFSET);
    wire addrHit = hitCtrl || hitStatus || hitWidth || hitScan || hitCount;
    wire wrCtrl = apbDone && pwrite && hitCtrl;
    wire wrStatus = apbDone && pwrite && hitStatus;

    // control fields
    wire acqOn = ctrlReg[PWC_ACQ_BIT];
    wire [PWC_TICK_W-1:0] tickSel = ctrlReg[PWC_TICK_LSB +: PWC_TICK_W];
    wire counter_width_select = ctrlReg[PWC_WIDTH_SEL_BIT];
    wire mapped_gate_enable = ctrlReg[PWC_GATE_EN_BIT];
    wire mapped_source_select = ctrlReg[PWC_SRC_SEL_BIT];
    wire [PWC_MAP_W-1:0] mapIdx = ctrlReg[PWC_MAP_LSB +: PWC_MAP_W];

    // acquisition start on a 0 to 1 write of the enable bit, stop on 0
    wire acqStart = wrCtrl && pwdata[PWC_ACQ_BIT] && !acqOn;
    wire acqStop = wrCtrl && !pwdata[PWC_ACQ_BIT];

    // mapped channel, falls back to own input when the index is out of range
    wire mapInRange = (int'(mapIdx) < NUM_INPUTS);
    wire mappedLevel = mapInRange ? debouncedIn[mapIdx] : debouncedIn[OWN_CHANNEL]; // [RQ12]
    wire mappedPol = mapInRange ? edgePolarity[mapIdx] : edgePolarity[OWN_CHANNEL];

    // measured source: own input or mapped channel
    wire srcNow = mapped_source_select ? mappedLevel : debouncedIn[OWN_CHANNEL]; // [RQ11]
    wire srcPol = mapped_source_select ? mappedPol : edgePolarity[OWN_CHANNEL]; // [RQ11]

    // edge detection against the previous core-clock sample
    wire srcRise = srcNow && !srcPrevReg; // [RQ16]
    wire srcFall = !srcNow && srcPrevReg; // [RQ16]
    // polarity high: rising starts, falling ends; low: the reverse
    wire startEdge = srcPol ? srcRise : srcFall; // [RQ1] [RQ2]
    wire endEdge = srcPol ? srcFall : srcRise; // [RQ1] [RQ2]

    // gating by the mapped channel
    wire gateOpen = !mapped_gate_enable || mappedLevel; // [RQ10]

    // saturation limit chosen by the width select
    wire [31:0] countMax = counter_width_select ? PWC_MAX32 : PWC_MAX16; // [RQ8]
    wire atMax = (countReg >= countMax); // [RQ9]

    // tick pulses from the four prescalers
    logic [3:0] tickPulses;
    wire tickSelected = tickPulses[tickSel]; // [RQ6]

    // count enable: measuring, tick present, gate open; the limit is checked apart
    wire countEn = (stateReg == PWC_MEASURE) && tickSelected && gateOpen; // [RQ16]

    // saturation event for the sticky status bit
    wire satEvent = countEn && atMax;

    // one prescaler per timebase setting, restarted with the acquisition
    pwc_prescaler #(.DIV(PWC_TICK0_CYC)) uTick0
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .restart(acqStart),
        .tickPulse(tickPulses[0])
    );
    pwc_prescaler #(.DIV(PWC_TICK1_CYC)) uTick1
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .restart(acqStart),
        .tickPulse(tickPulses[1])
    );
    pwc_prescaler #(.DIV(PWC_TICK2_CYC)) uTick2
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .restart(acqStart),
        .tickPulse(tickPulses[2])
    );
    pwc_prescaler #(.DIV(PWC_TICK3_CYC)) uTick3
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .restart(acqStart),
        .tickPulse(tickPulses[3])
    );

    // sequencer and counter next values
    always_comb
    begin
        stateNext = stateReg;
        countNext = countReg;
        widthNext = widthReg;
        if (acqStart)
        begin
            // fresh acquisition: count and width start from zero, wait for a start edge
            stateNext = PWC_WAIT_START;
            countNext = PWC_ZERO; // [RQ5]
            widthNext = PWC_ZERO; // [RQ5]
        end
        else if (acqStop)
        begin
            // stop: results are held for software
            stateNext = PWC_IDLE;
        end
        else
        begin
            case (stateReg)
                PWC_IDLE:
                begin
                    // nothing counts while idle
                    stateNext = PWC_IDLE;
                end
                PWC_WAIT_START:
                begin
                    // arm on the leading edge of the pulse
                    if (startEdge)
                    begin
                        stateNext = PWC_MEASURE;
                        countNext = PWC_ZERO;
                    end
                end
                PWC_MEASURE:
                begin
                    if (endEdge)
                    begin
                        // latch at once, clear and rearm for the next pulse
                        widthNext = countReg; // [RQ4] [RQ7] [RQ13]
                        countNext = PWC_ZERO; // [RQ3]
                        stateNext = PWC_WAIT_START; // [RQ3]
                    end
                    else if (countEn && !atMax)
                    begin
                        // one whole tick interval counted
                        countNext = countReg + 32'h0000_0001; // [RQ7]
                    end
                    else
                    begin
                        // held by gate, no tick, or saturated
                        countNext = countReg; // [RQ9] [RQ10]
                    end
                end
                default:
                begin
                    stateNext = PWC_IDLE;
                end
            endcase
        end
    end

    // read data selection
    wire [31:0] statusWord = {28'h000_0000, satStickyReg, validReg,
                              (stateReg == PWC_MEASURE), acqOn};
    wire [31:0] rdMux = hitCtrl ? {20'h0_0000, ctrlReg}
                      : hitStatus ? statusWord
                      : hitWidth ? widthReg
                      : hitScan ? scanReg
                      : hitCount ? countReg
                      : PWC_ZERO;

    // apb slave: one wait state, answer registered
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            preadyReg <= 1'b0;
            prdataReg <= PWC_ZERO;
            pslverrReg <= 1'b0;
        end
        else
        begin
            preadyReg <= apbAccess;
            prdataReg <= (apbAccess && !pwrite) ? rdMux : PWC_ZERO;
            pslverrReg <= apbAccess && !addrHit;
        end
    end

    // control register, written at the completing edge
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrlReg <= PWC_CTRL_RESET;
        end
        else if (wrCtrl)
        begin
            ctrlReg <= pwdata[11:0] & PWC_CTRL_MASK;
        end
    end

    // sticky saturation flag, write one to clear, a new event wins
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            satStickyReg <= 1'b0;
        end
        else if (satEvent)
        begin
            satStickyReg <= 1'b1;
        end
        else if (wrStatus && pwdata[PWC_ST_SAT_BIT])
        begin
            satStickyReg <= 1'b0;
        end
    end

    // sequencer, counter and width latch
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stateReg <= PWC_IDLE;
            countReg <= PWC_ZERO;
            widthReg <= PWC_ZERO;
            srcPrevReg <= 1'b0;
        end
        else
        begin
            stateReg <= stateNext;
            countReg <= countNext;
            widthReg <= widthNext;
            srcPrevReg <= srcNow;
        end
    end

    // capture pulse and first-result flag
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            captureReg <= 1'b0;
            validReg <= 1'b0;
        end
        else
        begin
            captureReg <= !acqStart && !acqStop && (stateReg == PWC_MEASURE) && endEdge;
            if (acqStart)
            begin
                validReg <= 1'b0;
            end
            else if ((stateReg == PWC_MEASURE) && endEdge && !acqStop)
            begin
                validReg <= 1'b1;
            end
        end
    end

    // scan latch: each strobe takes the newest width
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scanReg <= PWC_ZERO;
        end
        else if (acqStart)
        begin
            scanReg <= PWC_ZERO; // [RQ5]
        end
        else if (scanStrobe)
        begin
            scanReg <= widthNext; // [RQ14] [RQ15]
        end
    end

    // outputs straight from flip-flops
    assign prdata = prdataReg;
    assign pready = preadyReg;
    assign pslverr = pslverrReg;
    assign scanValue = scanReg;
    assign latchedWidth = widthReg;
    assign captureStrobe = captureReg;

endmodule

// ### inc/pwc_pkg.sv
package pwc_pkg;

    // core clock period in picoseconds (20 MHz)
    localparam int PWC_CLK_PERIOD_PS = 50000;

    // tick periods in picoseconds, as the four timebase settings
    localparam int PWC_TICK0_PS = 20830;
    localparam int PWC_TICK1_PS = 208300;
    localparam int PWC_TICK2_PS = 2083000;
    localparam int PWC_TICK3_PS = 20833000;

    // tick periods in core cycles, rounded down, never below one cycle
    localparam int PWC_TICK0_CYC = (PWC_TICK0_PS / PWC_CLK_PERIOD_PS < 1) ? 1
                                   : PWC_TICK0_PS / PWC_CLK_PERIOD_PS;
    localparam int PWC_TICK1_CYC = (PWC_TICK1_PS / PWC_CLK_PERIOD_PS < 1) ? 1
                                   : PWC_TICK1_PS / PWC_CLK_PERIOD_PS;
    localparam int PWC_TICK2_CYC = (PWC_TICK2_PS / PWC_CLK_PERIOD_PS < 1) ? 1
                                   : PWC_TICK2_PS / PWC_CLK_PERIOD_PS;
    localparam int PWC_TICK3_CYC = (PWC_TICK3_PS / PWC_CLK_PERIOD_PS < 1) ? 1
                                   : PWC_TICK3_PS / PWC_CLK_PERIOD_PS;

    // width of the prescaler cycle counter
    localparam int PWC_DIV_W = 16;

    // register byte offsets
    localparam logic [7:0] PWC_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] PWC_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] PWC_WIDTH_OFFSET = 8'h08;
    localparam logic [7:0] PWC_SCAN_OFFSET = 8'h0C;
    localparam logic [7:0] PWC_COUNT_OFFSET = 8'h10;

    // control register fields
    localparam int PWC_ACQ_BIT = 0;
    localparam int PWC_TICK_LSB = 1;
    localparam int PWC_TICK_W = 2;
    localparam int PWC_WIDTH_SEL_BIT = 3;
    localparam int PWC_GATE_EN_BIT = 4;
    localparam int PWC_SRC_SEL_BIT = 5;
    localparam int PWC_MAP_LSB = 8;
    localparam int PWC_MAP_W = 4;
    localparam logic [11:0] PWC_CTRL_MASK = 12'hF3F;
    localparam logic [11:0] PWC_CTRL_RESET = 12'h000;

    // status register fields
    localparam int PWC_ST_ACQ_BIT = 0;
    localparam int PWC_ST_MEAS_BIT = 1;
    localparam int PWC_ST_VALID_BIT = 2;
    localparam int PWC_ST_SAT_BIT = 3;

    // counter limits for the two widths
    localparam logic [31:0] PWC_MAX16 = 32'h0000_FFFF;
    localparam logic [31:0] PWC_MAX32 = 32'hFFFF_FFFF;
    localparam logic [31:0] PWC_ZERO = 32'h0000_0000;

    // measurement sequencer states
    typedef enum logic [1:0] {PWC_IDLE, PWC_WAIT_START, PWC_MEASURE} pwc_state_type;

endpackage

// ### hw/pwc_prescaler.sv
// divides the core clock down to one tick pulse every DIV cycles
module pwc_prescaler
    import pwc_pkg::*;
#(
    parameter int DIV = 1
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic restart,
    output logic tickPulse
);

    // cycle counter, counts DIV-1 down to zero
    logic [PWC_DIV_W-1:0] divCountReg;
    logic [PWC_DIV_W-1:0] divCountNext;
    logic atTerminal;

    localparam logic [PWC_DIV_W-1:0] DIV_LAST = PWC_DIV_W'(DIV - 1);

    assign atTerminal = (divCountReg == '0);
    assign divCountNext = (restart || atTerminal) ? DIV_LAST : divCountReg - 1'b1;

    // counter and registered terminal pulse
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            divCountReg <= '0;
            tickPulse <= 1'b0;
        end
        else
        begin
            divCountReg <= divCountNext;
            tickPulse <= atTerminal && !restart;
        end
    end

endmodule

// ### verification/pwc_checker.sv
module pwc_checker
    import pwc_pkg::*;
#(
    parameter int NUM_INPUTS = 16
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_INPUTS-1:0] debouncedIn,
    input wire logic [NUM_INPUTS-1:0] edgePolarity,
    input wire logic scanStrobe,
    input wire logic [31:0] scanValue,
    input wire logic [31:0] latchedWidth,
    input wire logic captureStrobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // last five input samples
    logic [4:0][NUM_INPUTS-1:0] dly;
    // some channel changed lately
    wire recentEdge = (debouncedIn != dly[0]) || (dly[0] != dly[1]) || (dly[1] != dly[2])
        || (dly[2] != dly[3]) || (dly[3] != dly[4]);
    // input history shifter
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n)
            dly <= '0;
        else
            dly <= {dly[3:0], debouncedIn};
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // first access cycle, then a one-cycle answer
    sequence s_access; psel && penable && !pready; endsequence
    sequence s_resp; pready ##1 !pready; endsequence
    property p_ready_after; s_access |=> s_resp; endproperty
    a_ready_after: assert property (p_ready_after)
        else $error("apb answer missing or too long");
    property p_err_data; pslverr |-> pready && prdata == PWC_ZERO; endproperty
    a_err_data: assert property (p_err_data)
        else $error("error answer with data or no ready");
    property p_rdata_idle; !pready |-> prdata == PWC_ZERO; endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside answer cycle");
    property p_cap_pulse; captureStrobe |=> !captureStrobe; endproperty
    a_cap_pulse: assert property (p_cap_pulse)
        else $error("capture strobe longer than one cycle");
    property p_cap_edge; captureStrobe |-> recentEdge; endproperty
    a_cap_edge: assert property (p_cap_edge)
        else $error("capture without an input edge");
    sequence s_cap_soon; captureStrobe or (1'b1 ##1 captureStrobe); endsequence
    property p_latch_cause; $changed(latchedWidth) && latchedWidth != PWC_ZERO |-> s_cap_soon; endproperty
    a_latch_cause: assert property (p_latch_cause)
        else $error("latched width changed without capture");
    property p_scan_follow; scanStrobe |=> scanValue == latchedWidth; endproperty
    a_scan_follow: assert property (p_scan_follow)
        else $error("scan value differs from latched width");
    property p_scan_hold; $changed(scanValue) |-> $past(scanStrobe) || scanValue == PWC_ZERO; endproperty
    a_scan_hold: assert property (p_scan_hold)
        else $error("scan value changed without strobe");
endmodule
bind pwc_pulse_width_counter pwc_checker #(.NUM_INPUTS(NUM_INPUTS)) i_pwc_checker (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debouncedIn(debouncedIn), .edgePolarity(edgePolarity), .scanStrobe(scanStrobe),
    .scanValue(scanValue), .latchedWidth(latchedWidth), .captureStrobe(captureStrobe));

// ### verification/pwc_partner.sv
module pwc_partner
    import pwc_pkg::*;
#(
    parameter int NUM_INPUTS = 16
)
(
    input wire logic core_clk,
    output logic [NUM_INPUTS-1:0] debouncedIn,
    output logic [NUM_INPUTS-1:0] edgePolarity,
    output logic scanStrobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // lines idle low, high pulses measured, no scan
    initial
    begin
        debouncedIn = '0;
        edgePolarity = '1;
        scanStrobe = 1'b0;
    end
    // inverts masked channels just after an edge
    task flip(input logic [NUM_INPUTS-1:0] m);
        @(posedge core_clk);
        debouncedIn <= debouncedIn ^ m;
    endtask
    // masked channels inverted for n cycles
    task pulse(input logic [NUM_INPUTS-1:0] m, input int n);
        flip(m);
        repeat (n - 1) @(posedge core_clk);
        flip(m);
    endtask
    // per channel edge polarity
    task setPol(input logic [NUM_INPUTS-1:0] p);
        @(posedge core_clk);
        edgePolarity <= p;
    endtask
    // one-cycle read strobe of this counter
    task scan;
        @(posedge core_clk);
        scanStrobe <= 1'b1;
        @(posedge core_clk);
        scanStrobe <= 1'b0;
    endtask
endmodule

// ### verification/pwc_pulse_width_counter_test.sv
module pwc_pulse_width_counter_test
    import pwc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst_n, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, scanValue, latchedWidth, rd, sd = 32'h0000_5075;
    logic pready, pslverr, captureStrobe, er, scanStrobe;
    logic [15:0] din, pol;
    int errTotal = 0, totalChecks = 0, n;
    pwc_pulse_width_counter i_pwc_pulse_width_counter (.core_clk(core_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .debouncedIn(din),
        .edgePolarity(pol), .scanStrobe(scanStrobe), .scanValue(scanValue),
        .latchedWidth(latchedWidth), .captureStrobe(captureStrobe));
    pwc_partner i_pwc_partner (.core_clk(core_clk), .debouncedIn(din), .edgePolarity(pol),
        .scanStrobe(scanStrobe));
    // 50 ns core clock
    initial
        forever #25 core_clk = ~core_clk;
    // compares within a tolerance of tol
    task chk(input logic [31:0] g, input logic [31:0] e, input int tol);
        totalChecks++;
        if ((^g === 1'bx) || (g + tol < e) || (g > e + tol))
        begin
            errTotal++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // one apb transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // restarts acquisition with settings c
    task start(input logic [11:0] c);
        // unused upper data bits carry random filler, the block must ignore them
        apb(1'b1, PWC_CTRL_OFFSET, {sd[31:12], 12'h000});
        apb(1'b1, PWC_CTRL_OFFSET, {sd[31:12], c | 12'h001});
    endtask
    // pulse, then wait a bounded time for capture
    task meas(input logic [15:0] m, input int w);
        i_pwc_partner.pulse(m, w);
        for (int k = 0; k < 8 && captureStrobe !== 1'b1; k++)
            @(posedge core_clk);
    endtask
    // scan twice, compare the reported width
    task scan2(input int e);
        i_pwc_partner.scan();
        i_pwc_partner.scan();
        @(posedge core_clk);
        chk(scanValue, e, 2);
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // core cycles of each tick setting
    function automatic int tc(input int t);
        return t == 0 ? PWC_TICK0_CYC : t == 1 ? PWC_TICK1_CYC : t == 2 ? PWC_TICK2_CYC
            : PWC_TICK3_CYC;
    endfunction
    task wrap_up;
        $display("checks %0d mismatches %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // main sequence
    initial
    begin
        // bus idle and reset asserted from time zero
        rst_n <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= PWC_CTRL_OFFSET;
        pwdata <= sd;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        chk(latchedWidth, PWC_ZERO, 0);
        apb(1'b0, PWC_CTRL_OFFSET, PWC_ZERO);
        chk(rd, PWC_ZERO, 0);
        apb(1'b0, 8'h40, PWC_ZERO);
        chk({31'h0000_0000, er}, 32'h0000_0001, 0);
        start(12'h000);
        scan2(0);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            sd = lfsr(sd);
            n = 10 + sd[7:0];
            meas(16'h0001, n);
            chk(latchedWidth, n, 2);
            scan2(n);
            apb(1'b0, PWC_COUNT_OFFSET, PWC_ZERO);
            chk(rd, PWC_ZERO, 0);
        end
        meas(16'h0001, 20);
        meas(16'h0001, 60);
        scan2(60);
        $display("test random done");
        i_pwc_partner.setPol(16'hFFFE);
        i_pwc_partner.flip(16'h0001);
        start(12'h000);
        meas(16'h0001, 30);
        chk(latchedWidth, 30, 2);
        i_pwc_partner.setPol(16'hFFFF);
        i_pwc_partner.flip(16'h0001);
        for (int t = 0; t < 4; t++)
        begin
            start(12'(t * 2));
            meas(16'h0001, tc(t) * 8);
            chk(latchedWidth, 8, 2);
        end
        start(12'h110);
        meas(16'h0001, 50);
        chk(latchedWidth, PWC_ZERO, 0);
        i_pwc_partner.flip(16'h0002);
        meas(16'h0001, 50);
        chk(latchedWidth, 50, 2);
        // gate closed for 30 of 70 high cycles: the count holds meanwhile
        i_pwc_partner.flip(16'h0001);
        repeat (19) @(posedge core_clk);
        i_pwc_partner.pulse(16'h0002, 30);
        repeat (19) @(posedge core_clk);
        i_pwc_partner.flip(16'h0001);
        repeat (3) @(posedge core_clk);
        chk(latchedWidth, 70 - 30, 2);
        i_pwc_partner.flip(16'h0002);
        start(12'h220);
        meas(16'h0004, 40);
        chk(latchedWidth, 40, 2);
        meas(16'h0001, 15);
        chk(latchedWidth, 40, 2);
        start(12'h008);
        meas(16'h0001, 70);
        chk(latchedWidth, 70, 2);
        start(12'h000);
        meas(16'h0001, 65600);
        chk(latchedWidth, PWC_MAX16, 0);
        // status: acquiring, waiting, valid, saturated; then clear the sticky bit
        apb(1'b0, PWC_STATUS_OFFSET, PWC_ZERO);
        chk(rd, 32'h0000_000D, 0);
        apb(1'b1, PWC_STATUS_OFFSET, 32'h0000_0008);
        apb(1'b0, PWC_STATUS_OFFSET, PWC_ZERO);
        chk(rd, 32'h0000_0005, 0);
        // mid-run reset: latched and scanned results go back to zero
        i_pwc_partner.scan();
        @(posedge core_clk);
        rst_n <= 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        chk(latchedWidth, PWC_ZERO, 0);
        chk(scanValue, PWC_ZERO, 0);
        $display("test modes done");
        wrap_up();
    end
    // watchdog
    initial
    begin
        // about 90,000 core cycles, the tests need some 72,000
        #4500000;
        errTotal++;
        wrap_up();
    end
endmodule
